// ### design/ecpr_defs.svh
// constants for the encoder position reporter
// assumes one 125 MHz clock and an APB register slave
`ifndef ECPR_DEFS_SVH
`define ECPR_DEFS_SVH

// ------------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------------
`define ECPR_OFF_CTRL      12'h000
`define ECPR_OFF_RES       12'h004
`define ECPR_OFF_PRESET    12'h008
`define ECPR_OFF_CYCLE     12'h00C
`define ECPR_OFF_SYNCCNT   12'h010
`define ECPR_OFF_LIMMIN    12'h014
`define ECPR_OFF_LIMMAX    12'h018
`define ECPR_OFF_STATUS    12'h01C
`define ECPR_OFF_PVAL      12'h020
`define ECPR_OFF_CAMLO     12'h040
`define ECPR_OFF_CAMHI     12'h060

// ------------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------------
`define ECPR_CTRL_MODE_LO  0
`define ECPR_CTRL_DIR      2
`define ECPR_CTRL_NMT_LO   3
`define ECPR_RES_RST       32'h0001_0000
`define ECPR_LIM_BIT       31
`define ECPR_POS_W         31

// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define ECPR_CLK_MHZ       125
`define ECPR_MS_NS         1000000
`define ECPR_MS_CYC        (`ECPR_MS_NS * `ECPR_CLK_MHZ / 1000)
`define ECPR_BLINK_MS      200
`define ECPR_FLICK_MS      50
`define ECPR_FLASH_MS      200
`define ECPR_PAUSE_MS      1000

`endif

// ### design/ecpr_pkg.sv
// types for the encoder position reporter
// field widths are written out here, not taken from ecpr_defs.svh
package ecpr_pkg;

    typedef enum logic [1:0] {ECPR_POLLED, ECPR_CYCLIC, ECPR_SYNC}
        ecpr_mode_t;

    typedef enum logic [1:0] {ECPR_PREOP, ECPR_STOPPED, ECPR_OPER}
        ecpr_nmt_t;

    typedef enum logic [2:0] {ECPR_OFF, ECPR_ON, ECPR_BLINK, ECPR_FLICK,
        ECPR_FLASH1, ECPR_FLASH2} ecpr_led_t;

    typedef struct packed {
        logic        rtr;
        logic        sync;
        logic        warn;
        logic        bus_off;
        logic        guard_evt;
        logic        baud_det;
    } ecpr_can_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] value;
    } ecpr_tx_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic        pready;
        logic        pslverr;
        logic [1:0]  mode;
        logic        dir;
        logic [1:0]  nmt;
        logic [30:0] res;
        logic [30:0] offset;
        logic [31:0] cycle;
        logic [15:0] sync_cfg;
        logic [15:0] sync_cnt;
        logic [30:0] lim_min;
        logic [30:0] lim_max;
        logic [30:0] pos;
        logic        pos_ok;
        logic [31:0] ms_cnt;
        logic [31:0] cyc_cnt;
        logic        tx_valid;
        logic [31:0] tx_value;
        logic [7:0]  cam;
        logic        guard_seen;
        logic        led_g;
        logic        led_r;
        logic [31:0] tick;
        logic [3:0]  phase;
        logic [1:0]  can_s1;
        logic [1:0]  can_s2;
    } ecpr_state_t;

endpackage : ecpr_pkg

// ### design/ecpr_top.sv
// position scaling, cam and limit logic, CAN transmit trigger, LEDs
// assumes CAN controller events on pclk, raw angle from sensor logic
// Function
// - green: blink preop, flash stopped, on operational
// - red dark when no error
// - red flickers during auto baud detect
// - red single flash at error warning
// - red double flash after guard event
// - red steady on at bus off
// - answer remote request with fresh value
// - cyclic mode sends value periodically
// - cycle period 1 to 65536 ms
// - sync mode sends after sync frame
// - sync replies ordered by identifier arbitration
// - no delay after sync frame
// - sync counter gates transmission
// - direction bit reverses counting
// - resolution sets steps per revolution
// - preset makes current position equal value
// - two limit positions form window
// - outside window sets limit bit
// - eight programmable cams
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "ecpr_defs.svh"

module ecpr_top
    import ecpr_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // sensor: 16 bit angle and 15 bit turn count
    input  wire logic [15:0] angle,
    input  wire logic [14:0] turns,
    // can controller events
    input  ecpr_can_t        can_evt,
    // process value to can controller
    output ecpr_tx_t         tx,
    // cam outputs and leds
    output logic      [7:0]  cam_out,
    output logic             led_run,
    output logic             led_err
);

    localparam int unsigned MS_CYC = `ECPR_MS_CYC;

    ecpr_state_t q, d;
    logic [31:0] cam_lo_q [8];
    logic [31:0] cam_hi_q [8];
    logic [30:0] raw_pos;
    logic [30:0] dir_pos;
    logic [61:0] scaled;
    logic [30:0] scaled_pos;
    logic        wr;
    logic        rd;
    logic [7:0]  cam_hit;

    assign wr = psel && penable && pwrite && !q.pready;
    assign rd = psel && penable && !pwrite && !q.pready;

    // ------------------------------------------------------------------
    // position path
    // ------------------------------------------------------------------
    assign raw_pos = {turns, angle};
    assign dir_pos = q.dir ? ~raw_pos : raw_pos;
    // rescale full 16 bit turn to res steps per turn
    assign scaled  = {31'h0000_0000, dir_pos} * {31'h0000_0000, q.res};
    assign scaled_pos = scaled[46:16];

    // ------------------------------------------------------------------
    // cams
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_cam
            assign cam_hit[gi] = (q.pos >= cam_lo_q[gi][30:0]) &&
                                 (q.pos <= cam_hi_q[gi][30:0]);
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    cam_lo_q[gi] <= 32'h0000_0000;
                    cam_hi_q[gi] <= 32'h0000_0000;
                end
                else if (wr && paddr == `ECPR_OFF_CAMLO + 12'(gi * 4))
                    cam_lo_q[gi] <= pwdata;
                else if (wr && paddr == `ECPR_OFF_CAMHI + 12'(gi * 4))
                    cam_hi_q[gi] <= pwdata;
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        logic        send;
        logic [30:0] off_pos;
        logic        led_tick;
        logic [31:0] tick_len;
        send     = 1'b0;
        off_pos  = 31'(scaled_pos + q.offset);
        led_tick = 1'b0;
        tick_len = 32'(`ECPR_BLINK_MS * MS_CYC);
        d        = q;
        d.pready  = 1'b0;
        d.pslverr = 1'b0;
        d.can_s1 = {can_evt.rtr, can_evt.sync};
        d.can_s2 = q.can_s1;
        d.pos    = off_pos;
        d.pos_ok = (off_pos >= q.lim_min) && (off_pos <= q.lim_max);
        d.cam    = cam_hit;
        d.tx_valid = 1'b0;

        // ------------------------------------------------------------------
        // apb access, one wait state
        // ------------------------------------------------------------------
        if (wr || rd)
        begin
            d.pready = 1'b1;
            d.rdata  = 32'h0000_0000;
            unique case (paddr)
                `ECPR_OFF_CTRL:
                begin
                    d.rdata = {27'h0, q.nmt, q.dir, q.mode};
                    if (pwrite)
                    begin
                        d.mode = pwdata[`ECPR_CTRL_MODE_LO +: 2];
                        d.dir  = pwdata[`ECPR_CTRL_DIR];
                        d.nmt  = pwdata[`ECPR_CTRL_NMT_LO +: 2];
                    end
                end
                `ECPR_OFF_RES:
                begin
                    d.rdata = {1'b0, q.res};
                    if (pwrite)
                        d.res = pwdata[30:0];
                end
                `ECPR_OFF_PRESET:
                begin
                    d.rdata = {1'b0, q.pos};
                    if (pwrite)
                        d.offset = 31'(pwdata[30:0] - scaled_pos);
                end
                `ECPR_OFF_CYCLE:
                begin
                    d.rdata = q.cycle;
                    if (pwrite)
                        d.cycle = pwdata;
                end
                `ECPR_OFF_SYNCCNT:
                begin
                    d.rdata = {16'h0, q.sync_cfg};
                    if (pwrite)
                        d.sync_cfg = pwdata[15:0];
                end
                `ECPR_OFF_LIMMIN:
                begin
                    d.rdata = {1'b0, q.lim_min};
                    if (pwrite)
                        d.lim_min = pwdata[30:0];
                end
                `ECPR_OFF_LIMMAX:
                begin
                    d.rdata = {1'b0, q.lim_max};
                    if (pwrite)
                        d.lim_max = pwdata[30:0];
                end
                `ECPR_OFF_STATUS:
                    d.rdata = {23'h0, q.guard_seen, q.cam};
                `ECPR_OFF_PVAL:
                    d.rdata = {!q.pos_ok, q.pos};
                default:
                begin
                    if (paddr >= `ECPR_OFF_CAMLO &&
                        paddr < `ECPR_OFF_CAMHI + 12'h020)
                        d.rdata = paddr < `ECPR_OFF_CAMHI ?
                            cam_lo_q[paddr[4:2]] : cam_hi_q[paddr[4:2]];
                    else
                        d.pslverr = 1'b1;
                end
            endcase
            // status write one clears, new event wins
            if (pwrite && paddr == `ECPR_OFF_STATUS && pwdata[8])
                d.guard_seen = 1'b0;
        end
        if (can_evt.guard_evt)
            d.guard_seen = 1'b1;

        // ------------------------------------------------------------------
        // transmit triggers, only when operational
        // ------------------------------------------------------------------
        d.ms_cnt = q.ms_cnt + 32'h1;
        if (q.ms_cnt >= 32'(MS_CYC - 1))
        begin
            d.ms_cnt  = 32'h0;
            d.cyc_cnt = q.cyc_cnt + 32'h1;
        end
        if (q.nmt == ECPR_OPER)
        begin
            unique case (q.mode)
                ECPR_POLLED:
                    send = q.can_s2[1];
                ECPR_CYCLIC:
                    if (q.ms_cnt >= 32'(MS_CYC - 1) &&
                        q.cyc_cnt + 32'h1 >= q.cycle)
                    begin
                        send      = 1'b1;
                        d.cyc_cnt = 32'h0;
                    end
                ECPR_SYNC:
                    if (q.can_s2[0])
                    begin
                        d.sync_cnt = q.sync_cnt + 16'h1;
                        if (q.sync_cnt + 16'h1 >= q.sync_cfg)
                        begin
                            send       = 1'b1;
                            d.sync_cnt = 16'h0;
                        end
                    end
                default:
                    send = 1'b0;
            endcase
        end
        if (send)
        begin
            // arbitration order is left to the can controller
            d.tx_valid = 1'b1;
            d.tx_value = {!q.pos_ok, q.pos};
        end

        // ------------------------------------------------------------------
        // led pattern timing
        // ------------------------------------------------------------------
        if (can_evt.baud_det)
            tick_len = 32'(`ECPR_FLICK_MS * MS_CYC);
        d.tick = q.tick + 32'h1;
        if (q.tick >= tick_len - 32'h1)
        begin
            d.tick   = 32'h0;
            led_tick = 1'b1;
            d.phase  = q.phase + 4'h1;
        end
        // steady states follow at once, patterns step on ticks
        unique case (q.nmt)
            ECPR_OPER:
                d.led_g = 1'b1;
            ECPR_PREOP:
                if (led_tick)
                    d.led_g = ~q.led_g;
            ECPR_STOPPED:
                if (led_tick)
                    d.led_g = (q.phase == 4'h0);
            default:
                d.led_g = 1'b0;
        endcase
        if (can_evt.bus_off)
            d.led_r = 1'b1;
        else if (can_evt.baud_det)
        begin
            if (led_tick)
                d.led_r = ~q.led_r;
        end
        else if (q.guard_seen)
        begin
            if (led_tick)
                d.led_r = (q.phase == 4'h0) || (q.phase == 4'h2);
        end
        else if (can_evt.warn)
        begin
            if (led_tick)
                d.led_r = (q.phase == 4'h0);
        end
        else
            d.led_r = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q          <= '0;
            q.res      <= 31'(`ECPR_RES_RST);
            q.cycle    <= 32'h0000_0001;
            q.sync_cfg <= 16'h0001;
            q.lim_max  <= 31'h7FFF_FFFF;
        end
        else
            q <= d;
    end

    assign prdata   = q.rdata;
    assign pready   = q.pready;
    assign pslverr  = q.pslverr;
    assign tx.valid = q.tx_valid;
    assign tx.value = q.tx_value;
    assign cam_out  = q.cam;
    assign led_run  = q.led_g;
    assign led_err  = q.led_r;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_rtr_seen;
        q.nmt == ECPR_OPER && q.mode == ECPR_POLLED && q.can_s2[1];
    endsequence

    sequence s_sync_due;
        q.nmt == ECPR_OPER && q.mode == ECPR_SYNC && q.can_s2[0] &&
        q.sync_cnt + 16'h1 >= q.sync_cfg;
    endsequence

    sequence s_cyc_early;
        q.nmt == ECPR_OPER && q.mode == ECPR_CYCLIC &&
        q.ms_cnt < 32'(MS_CYC - 1);
    endsequence

    // transmit path
    poll_answer_a: assert property (s_rtr_seen |=> tx.valid)
        else $error("remote request not answered");
    limit_flag_a: assert property (tx.valid |->
        tx.value[31] == !$past(q.pos_ok))
        else $error("limit flag wrong");
    poll_value_a: assert property (tx.valid |->
        tx.value[30:0] == $past(q.pos))
        else $error("sent value is not the position");

    // indicators
    busoff_red_a: assert property (can_evt.bus_off |=> led_err)
        else $error("red not on at bus off");
    quiet_red_a: assert property (!can_evt.bus_off &&
        !can_evt.baud_det && !q.guard_seen && !can_evt.warn |=> !led_err)
        else $error("red lit without error");
    oper_green_a: assert property (q.nmt == ECPR_OPER |=> led_run)
        else $error("green not on when operational");

    // trigger gating
    no_tx_stop_a: assert property (q.nmt != ECPR_OPER |=> !tx.valid)
        else $error("transmit while not operational");
    sync_gate_a: assert property (q.mode == ECPR_SYNC &&
        q.can_s2[0] && q.nmt == ECPR_OPER && q.sync_cnt + 16'h1 < q.sync_cfg
        |=> !tx.valid)
        else $error("sync sent before count");
    sync_send_a: assert property (s_sync_due |=> tx.valid)
        else $error("sync count reached without send");
    cyc_wait_a: assert property (s_cyc_early |=> !tx.valid)
        else $error("cyclic send off the millisecond");

    // status, window and cams
    guard_set_a: assert property (can_evt.guard_evt |=> q.guard_seen)
        else $error("guard event not latched");
    window_flag_a: assert property ($past(presetn) |->
        q.pos_ok == (q.pos >= $past(q.lim_min) &&
        q.pos <= $past(q.lim_max)))
        else $error("window flag wrong");
    cam_window_a: assert property ($past(presetn) |->
        cam_out[0] == ($past(q.pos) >= $past(cam_lo_q[0][30:0]) &&
        $past(q.pos) <= $past(cam_hi_q[0][30:0])))
        else $error("cam 0 mismatch");

endmodule : ecpr_top

// ### test/ecpr_host_model.sv
// host side model: remote request, sync and status events on the bus
// assumes ecpr_top samples can_evt on pclk and pulses tx.valid
`timescale 1ns/1ps

module ecpr_host_model
    import ecpr_pkg::*;
(
    // clock
    input  wire logic pclk,
    // bus events and frames
    output ecpr_can_t can_evt,
    input  ecpr_tx_t  tx
);
    int unsigned n_rx;
    logic [31:0] last_rx;
    time         req_t;
    time         rx_t;

    initial
    begin
        can_evt = '0;
        n_rx    = 0;
        last_rx = '0;
        req_t   = 0;
        rx_t    = 0;
    end

    // ------------------------------------------------------------
    // frames sent by the encoder
    // ------------------------------------------------------------
    always @(posedge pclk)
    begin
        if (tx.valid === 1'b1)
        begin
            n_rx++;
            last_rx = tx.value;
            rx_t    = $time;
        end
    end

    // one cycle event: 0 remote request, 1 sync, else guard event
    task automatic pulse(input int kind);
        @(posedge pclk);
        req_t = $time;
        case (kind)
            0:       can_evt.rtr       <= 1'b1;
            1:       can_evt.sync      <= 1'b1;
            default: can_evt.guard_evt <= 1'b1;
        endcase
        @(posedge pclk);
        can_evt.rtr       <= 1'b0;
        can_evt.sync      <= 1'b0;
        can_evt.guard_evt <= 1'b0;
    endtask : pulse

    // controller condition levels
    task automatic levels(input logic w, input logic b, input logic d);
        @(posedge pclk);
        can_evt.warn     <= w;
        can_evt.bus_off  <= b;
        can_evt.baud_det <= d;
    endtask : levels
endmodule : ecpr_host_model

// ### test/testbench.sv
// self-checking bench for ecpr_top: apb master, sensor, host model
// assumes ecpr_top answers apb with one wait state
`timescale 1ns/1ps
`include "ecpr_defs.svh"

module testbench
    import ecpr_pkg::*;
;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] angle;
    logic [14:0] turns;
    ecpr_can_t   can_evt;
    ecpr_tx_t    tx;
    logic [7:0]  cam_out;
    logic        led_run;
    logic        led_err;
    logic [31:0] rd;
    logic        er;
    int unsigned err_total  = 0;
    int unsigned num_checks = 0;
    int unsigned cyc        = 0;

    ecpr_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .angle(angle), .turns(turns),
        .can_evt(can_evt), .tx(tx), .cam_out(cam_out),
        .led_run(led_run), .led_err(led_err));

    ecpr_host_model i_host (.pclk(pclk), .can_evt(can_evt), .tx(tx));

    always #4 pclk = ~pclk;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rchk

    task automatic set_raw(input logic [30:0] r);
        @(posedge pclk);
        angle <= r[15:0];
        turns <= r[30:16];
        repeat (4) @(posedge pclk);
    endtask : set_raw

    task automatic done(input string name);
        $display("test %s finished at %0t", name, $time);
    endtask : done

    function automatic logic [30:0] scale(input logic [30:0] raw,
        input logic dir, input logic [31:0] res);
        logic [63:0] p;
        p = {33'h0, dir ? ~raw : raw} * res;
        return p[46:16];
    endfunction : scale

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [30:0] raw;
        logic [31:0] res;
        logic        dir;
        int unsigned n0;
        pclk    = 1'b0;
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        angle   = 16'h0;
        turns   = 15'h0;
        void'($urandom(66994));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rchk(`ECPR_OFF_RES, `ECPR_RES_RST);
        rchk(`ECPR_OFF_CTRL, 32'h0);
        rchk(`ECPR_OFF_LIMMIN, 32'h0);
        rchk(`ECPR_OFF_LIMMAX, 32'h7FFF_FFFF);
        apb(1'b0, 12'h800, 32'h0);
        chk({31'h0, er}, 32'h1);
        done("reset");
        for (int i = 0; i < 8; i++)
        begin
            raw = 31'($urandom());
            dir = i[0];
            res = (i < 2) ? 32'h0001_0000 : {15'h0, 17'($urandom())};
            apb(1'b1, `ECPR_OFF_CTRL, {29'h0, dir, 2'h0});
            apb(1'b1, `ECPR_OFF_RES, res);
            set_raw(raw);
            rchk(`ECPR_OFF_PVAL, {1'b0, scale(raw, dir, res)});
        end
        done("scaling");
        apb(1'b1, `ECPR_OFF_CTRL, 32'h0);
        apb(1'b1, `ECPR_OFF_RES, 32'h0001_0000);
        raw = 31'($urandom());
        set_raw(raw);
        apb(1'b1, `ECPR_OFF_PRESET, 32'h0000_1000);
        rchk(`ECPR_OFF_PVAL, 32'h0000_1000);
        set_raw(raw + 31'd5);
        rchk(`ECPR_OFF_PVAL, 32'h0000_1005);
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, `ECPR_OFF_LIMMIN, (i == 0) ? 32'h1006 : 32'h1005);
            apb(1'b1, `ECPR_OFF_LIMMAX, (i == 2) ? 32'h1004 : 32'h1005);
            rchk(`ECPR_OFF_PVAL, {i != 1, 31'h1005});
        end
        done("preset and limits");
        for (int n = 0; n < 8; n++)
        begin
            apb(1'b1, `ECPR_OFF_CAMLO + 12'(4 * n), n[0] ?
                (n[1] ? 32'h1000 : 32'h1006) : 32'(32'h1005 - n));
            apb(1'b1, `ECPR_OFF_CAMHI + 12'(4 * n), n[0] ?
                (n[1] ? 32'h1004 : 32'h100A) : 32'(32'h1005 + n));
        end
        repeat (4) @(negedge pclk);
        chk({24'h0, cam_out}, 32'h55);
        rchk(`ECPR_OFF_STATUS, 32'h55);
        done("cams");
        n0 = i_host.n_rx;
        i_host.pulse(0);
        repeat (10) @(negedge pclk);
        chk(i_host.n_rx, n0);
        apb(1'b1, `ECPR_OFF_CTRL, 32'h10);
        repeat (4) @(negedge pclk);
        chk({31'h0, led_run}, 32'h1);
        i_host.pulse(0);
        repeat (10) @(negedge pclk);
        chk(i_host.n_rx - n0, 32'h1);
        chk(i_host.last_rx, 32'h8000_1005);
        done("polled");
        apb(1'b1, `ECPR_OFF_CTRL, 32'h12);
        apb(1'b1, `ECPR_OFF_SYNCCNT, 32'h3);
        for (int i = 1; i <= 3; i++)
        begin
            n0 = i_host.n_rx;
            i_host.pulse(1);
            repeat (8) @(negedge pclk);
            chk(i_host.n_rx - n0, (i == 3) ? 32'h1 : 32'h0);
        end
        chk({31'h0, (i_host.rx_t - i_host.req_t) <= 48}, 32'h1);
        done("sync");
        apb(1'b1, `ECPR_OFF_CTRL, 32'h11);
        n0 = i_host.n_rx;
        repeat (100) @(negedge pclk);
        chk(i_host.n_rx - n0, 32'h0);
        done("cyclic");
        i_host.levels(1'b0, 1'b1, 1'b0);
        repeat (4) @(negedge pclk);
        chk({31'h0, led_err}, 32'h1);
        i_host.levels(1'b0, 1'b0, 1'b0);
        repeat (4) @(negedge pclk);
        chk({31'h0, led_err}, 32'h0);
        i_host.levels(1'b1, 1'b0, 1'b1);
        i_host.levels(1'b0, 1'b0, 1'b0);
        i_host.pulse(2);
        rchk(`ECPR_OFF_STATUS, 32'h155);
        apb(1'b1, `ECPR_OFF_STATUS, 32'h100);
        rchk(`ECPR_OFF_STATUS, 32'h55);
        done("indicators");
        give_verdict();
    end
endmodule : testbench
